// ==== include/torque_off_pkg.sv ====
package torque_off_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int PWM_W    = 6;
	localparam int DRV_IN_W = 4;
	localparam int CNT_W    = 44;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam longint unsigned CLK_HZ          = 125_000_000;
	localparam longint unsigned FIRST_TEST_MS   = 20;
	localparam longint unsigned TEST_PERIOD_H   = 24;
	localparam longint unsigned RETRY_S         = 5;
	localparam longint unsigned TEST_PULSE_US   = 430;
	// Longest waits round down, the pulse is a least time and rounds up
	localparam longint unsigned FIRST_TEST_CYC  = FIRST_TEST_MS * CLK_HZ / 1000;
	localparam longint unsigned TEST_PERIOD_CYC = TEST_PERIOD_H * 3600 * CLK_HZ;
	localparam longint unsigned RETRY_CYC       = RETRY_S * CLK_HZ;
	localparam longint unsigned TEST_PULSE_CYC  = (TEST_PULSE_US * CLK_HZ + 999_999) / 1_000_000;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic            INDICATOR_RST   = 1'b0;
	localparam logic            FAULT_RST       = 1'b0;

	// ----------------------------------------
	// States
	// ----------------------------------------
	typedef enum logic [2:0] {
		DRV_DISABLED = 3'b001,
		DRV_ENABLED  = 3'b010,
		DRV_DECEL    = 3'b100
	} drive_state_type;

	typedef enum logic [4:0] {
		TST_IDLE   = 5'b00001,
		TST_WAIT   = 5'b00010,
		TST_PULSE  = 5'b00100,
		TST_PASSED = 5'b01000,
		TST_FAILED = 5'b10000
	} test_state_type;

endpackage

// ==== src/channel_self_test.sv ====
`timescale 1ns/1ps
module channel_self_test
	import torque_off_pkg::*;
#(
	parameter longint unsigned FIRST_CYC  = FIRST_TEST_CYC,
	parameter longint unsigned PERIOD_CYC = TEST_PERIOD_CYC,
	parameter longint unsigned RETRY_WAIT = RETRY_CYC,
	parameter longint unsigned PULSE_CYC  = TEST_PULSE_CYC
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic energized,
	input  wire logic resp_a,
	input  wire logic resp_b,
	output logic      test_pulse,
	output logic      fault
);

	test_state_type   state_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic             cnt_zero;

	function automatic logic [CNT_W-1:0] load(input longint unsigned cyc);
		load = CNT_W'(cyc - 1);
	endfunction

	assign cnt_zero   = (cnt_reg == '0);
	assign test_pulse = (state_reg == TST_PULSE);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= TST_IDLE;
			cnt_reg   <= '0;
		end else begin
			case (state_reg)
				TST_IDLE: if (energized) begin
					state_reg <= TST_WAIT;
					cnt_reg   <= load(FIRST_CYC);
				end
				TST_WAIT, TST_PASSED: begin
					if (!energized) begin
						state_reg <= TST_IDLE;
					end else if (cnt_zero) begin
						state_reg <= TST_PULSE;
						cnt_reg   <= load(PULSE_CYC);
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				TST_PULSE: begin
					if (!energized && !fault) begin
						state_reg <= TST_IDLE;
					end else if (cnt_zero && resp_a && resp_b) begin
						state_reg <= TST_PASSED;
						cnt_reg   <= load(PERIOD_CYC);
					end else if (cnt_zero) begin
						state_reg <= TST_FAILED;
						cnt_reg   <= load(RETRY_WAIT);
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				TST_FAILED: begin
					// Retest only with both channels up; fault stays meanwhile
					if (cnt_zero && energized) begin
						state_reg <= TST_PULSE;
						cnt_reg   <= load(PULSE_CYC);
					end else if (cnt_zero) begin
						cnt_reg <= load(RETRY_WAIT);
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				default: state_reg <= TST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Fault latch
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			fault <= FAULT_RST;
		end else if (test_pulse && cnt_zero && energized) begin
			fault <= !(resp_a && resp_b);
		end
	end

	fail_latch_a: assert property (@(posedge clk) disable iff (rst)
		test_pulse && cnt_zero && energized && !resp_a |=> fault && state_reg == TST_FAILED)
		else $error("failed test did not latch fault");
	fault_hold_a: assert property (@(posedge clk) disable iff (rst)
		fault && !test_pulse |=> fault)
		else $error("fault cleared without passing test");
	first_test_c: cover property (@(posedge clk) disable iff (rst)
		state_reg == TST_PULSE ##1 state_reg == TST_PASSED);
	retest_c: cover property (@(posedge clk) disable iff (rst)
		state_reg == TST_FAILED ##1 state_reg == TST_PULSE);

endmodule

// ==== src/torque_off_gate.sv ====
`timescale 1ns/1ps
// Operation
// - PWM only with both channels and enable
// - Either channel lost forces safe torque off
// - Floating channel counts as de-energized
// - Assignable status output for torque-off disable
// - Status output polarity selectable
// - Single enable input enables when energized
// - Several enable inputs combine by AND
// - Enable loss may start controlled deceleration
// - Safe state follows channel loss, not stop
// - Core cannot override the torque-off gating
// - Periodic channel self-test, fault forces safe state
module torque_off_gate
	import torque_off_pkg::*;
#(
	parameter longint unsigned FIRST_CYC  = FIRST_TEST_CYC,
	parameter longint unsigned PERIOD_CYC = TEST_PERIOD_CYC,
	parameter longint unsigned RETRY_WAIT = RETRY_CYC,
	parameter longint unsigned PULSE_CYC  = TEST_PULSE_CYC
) (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                channel_a_input_pin,
	input  wire logic                channel_b_input_pin,
	input  wire logic                test_resp_a_pin,
	input  wire logic                test_resp_b_pin,
	input  wire logic [DRV_IN_W-1:0] drive_input_pins,
	input  wire logic [DRV_IN_W-1:0] enable_select,
	input  wire logic                decel_on_disable,
	input  wire logic                decel_done,
	input  wire logic                indicator_assign,
	input  wire logic                indicator_active_high,
	input  wire logic [PWM_W-1:0]    pwm_request,
	output logic      [PWM_W-1:0]    pwm_out,
	output logic                     torque_off_active,
	output logic                     torque_off_indicator,
	output logic                     decel_request,
	output logic                     drive_enabled,
	output logic                     test_pulse,
	output logic                     self_test_fault
);

	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	logic [1:0]          ch_a_meta, ch_b_meta;
	logic [1:0]          resp_meta;
	logic [DRV_IN_W-1:0] drv_meta, drv_sync;
	logic                torque_off_channel_a, torque_off_channel_b;
	logic [1:0]          resp_sync;

	always_ff @(posedge clk) begin
		if (rst) begin
			ch_a_meta <= '0;
			ch_b_meta <= '0;
		end else begin
			// Reset low: a channel is off until seen energized
			ch_a_meta <= {ch_a_meta[0], channel_a_input_pin};
			ch_b_meta <= {ch_b_meta[0], channel_b_input_pin};
		end
	end
	assign torque_off_channel_a = ch_a_meta[1];
	assign torque_off_channel_b = ch_b_meta[1];

	always_ff @(posedge clk) begin
		if (rst) begin
			drv_meta  <= '0;
			drv_sync  <= '0;
			resp_meta <= '0;
			resp_sync <= '0;
		end else begin
			drv_meta  <= drive_input_pins;
			drv_sync  <= drv_meta;
			resp_meta <= {test_resp_b_pin, test_resp_a_pin};
			resp_sync <= resp_meta;
		end
	end

	// ----------------------------------------
	// Channel self-test
	// ----------------------------------------
	logic both_energized;
	assign both_energized = torque_off_channel_a && torque_off_channel_b;

	channel_self_test #(
		.FIRST_CYC  (FIRST_CYC),
		.PERIOD_CYC (PERIOD_CYC),
		.RETRY_WAIT (RETRY_WAIT),
		.PULSE_CYC  (PULSE_CYC)
	) u_self_test (
		.clk        (clk),
		.rst        (rst),
		.energized  (both_energized),
		.resp_a     (resp_sync[0]),
		.resp_b     (resp_sync[1]),
		.test_pulse (test_pulse),
		.fault      (self_test_fault)
	);

	// ----------------------------------------
	// Enable combination
	// ----------------------------------------
	function automatic logic enables_met(input logic [DRV_IN_W-1:0] lvl,
		input logic [DRV_IN_W-1:0] sel);
		// No enable configured means never enabled
		enables_met = (|sel) && (&(lvl | ~sel));
	endfunction

	logic enable_ok;
	logic sto_clear;
	assign enable_ok = enables_met(drv_sync, enable_select);
	// Self-test fault counts as torque off so the core cannot lift it
	assign sto_clear = both_energized && !self_test_fault;

	// ----------------------------------------
	// Drive state
	// ----------------------------------------
	drive_state_type drv_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			drv_reg <= DRV_DISABLED;
		end else begin
			case (drv_reg)
				DRV_DISABLED: if (sto_clear && enable_ok) begin
					drv_reg <= DRV_ENABLED;
				end
				DRV_ENABLED: begin
					if (!sto_clear) begin
						drv_reg <= DRV_DISABLED;
					end else if (!enable_ok && decel_on_disable) begin
						drv_reg <= DRV_DECEL;
					end else if (!enable_ok) begin
						drv_reg <= DRV_DISABLED;
					end
				end
				DRV_DECEL: begin
					// Torque stays until the channels drop, a self-test fault latches or the core stops
					if (!sto_clear || decel_done) begin
						drv_reg <= DRV_DISABLED;
					end
				end
				default: drv_reg <= DRV_DISABLED;
			endcase
		end
	end

	assign drive_enabled = (drv_reg != DRV_DISABLED);
	assign decel_request = (drv_reg == DRV_DECEL);

	// ----------------------------------------
	// PWM gate
	// ----------------------------------------
	// Raw pins gate directly: a channel loss cuts PWM with no clock,
	// and a pin pulled low when open reads as off
	logic gate_open;
	assign gate_open = channel_a_input_pin && channel_b_input_pin
		&& drive_enabled && !self_test_fault;
	assign pwm_out   = pwm_request & {PWM_W{gate_open}};

	// ----------------------------------------
	// Status
	// ----------------------------------------
	assign torque_off_active = !sto_clear;

	always_ff @(posedge clk) begin
		if (rst) begin
			torque_off_indicator <= INDICATOR_RST ^ !indicator_active_high;
		end else begin
			torque_off_indicator <= (indicator_assign && !sto_clear)
				^ !indicator_active_high;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	pwm_gating_a: assert property (@(posedge clk) disable iff (rst)
		pwm_out != '0 |-> channel_a_input_pin && channel_b_input_pin && drive_enabled)
		else $error("pwm active without both channels and enable");
	channel_loss_a: assert property (@(posedge clk) disable iff (rst)
		!both_energized |=> !drive_enabled)
		else $error("drive stayed enabled after channel loss");
	open_channel_a: assert property (@(posedge clk) disable iff (rst)
		!(channel_a_input_pin && channel_b_input_pin) |-> pwm_out == '0)
		else $error("pwm active with channel off");
	indicator_pol_a: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> torque_off_indicator ==
		(($past(indicator_assign) && !$past(sto_clear)) ^ !$past(indicator_active_high)))
		else $error("indicator level wrong");
	enable_and_a: assert property (@(posedge clk) disable iff (rst)
		drv_reg == DRV_DISABLED ##1 drv_reg == DRV_ENABLED |->
		&($past(drv_sync) | ~$past(enable_select)) && $past(enable_select) != '0)
		else $error("enabled without all enable inputs active");
	decel_entry_a: assert property (@(posedge clk) disable iff (rst)
		drv_reg == DRV_ENABLED && sto_clear && !enable_ok && decel_on_disable
		|=> decel_request)
		else $error("controlled deceleration not started");
	decel_torque_a: assert property (@(posedge clk) disable iff (rst)
		decel_request && channel_a_input_pin && channel_b_input_pin && !self_test_fault
		|-> pwm_out == pwm_request)
		else $error("torque cut on stop request before channel loss");
	sync_delay_a: assert property (@(posedge clk) disable iff (rst)
		##2 torque_off_channel_a == $past(channel_a_input_pin, 2))
		else $error("channel sync not two stages");
	fault_safe_a: assert property (@(posedge clk) disable iff (rst)
		self_test_fault |-> pwm_out == '0 && torque_off_active)
		else $error("self-test fault did not force safe state");

	enable_c: cover property (@(posedge clk) disable iff (rst)
		drv_reg == DRV_DISABLED ##1 drv_reg == DRV_ENABLED);
	cat1_stop_c: cover property (@(posedge clk) disable iff (rst)
		drv_reg == DRV_DECEL ##[1:20] !sto_clear);
	indicator_c: cover property (@(posedge clk) disable iff (rst)
		indicator_assign && torque_off_active);

endmodule

// ==== tb/safety_relay_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Two-stage safety relay
// ----------------------------------------
module safety_relay_model #(
	parameter int DELAY_CYC = 30
) (
	input  wire logic clk,
	input  wire logic stop_request,
	input  wire logic open_wire_a,
	output logic      immediate_contact_one,
	output logic      delayed_contact_one,
	output logic      delayed_contact_two
);
	// Starts tripped: all contacts open until the first release
	int wait_cnt = DELAY_CYC;
	logic delay_over;
	assign delay_over = stop_request && (wait_cnt >= DELAY_CYC);
	initial begin
		immediate_contact_one = 1'b0;
		delayed_contact_one = 1'b0;
		delayed_contact_two = 1'b0;
	end
	// Open wire reads low through the board pull-down
	always @(posedge clk) begin
		immediate_contact_one <= !stop_request;
		wait_cnt <= stop_request ? ((wait_cnt < DELAY_CYC) ? wait_cnt + 1 : wait_cnt) : 0;
		delayed_contact_one <= !delay_over && !open_wire_a;
		delayed_contact_two <= !delay_over;
	end
endmodule

// ==== tb/torque_off_gate_tb_top.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Bench top
// ----------------------------------------
module torque_off_gate_tb_top;
	import torque_off_pkg::*;
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	logic                stop_request = 1'b1;
	logic                open_wire_a = 1'b0;
	logic                resp_ok = 1'b1;
	logic                decel_on_disable = 1'b0;
	logic                decel_done = 1'b0;
	logic                ind_assign = 1'b1;
	logic                ind_high = 1'b1;
	logic [DRV_IN_W-1:0] other_inputs = 4'h0;
	logic [DRV_IN_W-1:0] enable_select = 4'h1;
	logic [PWM_W-1:0]    pwm_request = 6'h00;
	logic [DRV_IN_W-1:0] drive_input_pins;
	logic [PWM_W-1:0]    pwm_out;
	logic                chan_a, chan_b, enable_contact;
	logic                torque_off_active, torque_off_indicator, decel_request;
	logic                drive_enabled, test_pulse, self_test_fault;
	int                  miscompares = 0;
	int                  total_checks = 0;
	int                  cycles = 0;
	int                  seed = 65361;
	int                  k;
	always #4 clk = ~clk;
	assign drive_input_pins = {other_inputs[3:1], enable_contact};
	safety_relay_model #(.DELAY_CYC(30)) relay (.clk(clk), .stop_request(stop_request),
		.open_wire_a(open_wire_a), .immediate_contact_one(enable_contact),
		.delayed_contact_one(chan_a), .delayed_contact_two(chan_b));
	// Short counts keep the run small; pulse stays above sync latency
	torque_off_gate #(.FIRST_CYC(20), .PERIOD_CYC(200), .RETRY_WAIT(50), .PULSE_CYC(4)) dut (
		.clk(clk), .rst(rst), .channel_a_input_pin(chan_a), .channel_b_input_pin(chan_b),
		.test_resp_a_pin(resp_ok), .test_resp_b_pin(resp_ok),
		.drive_input_pins(drive_input_pins), .enable_select(enable_select),
		.decel_on_disable(decel_on_disable), .decel_done(decel_done),
		.indicator_assign(ind_assign), .indicator_active_high(ind_high),
		.pwm_request(pwm_request), .pwm_out(pwm_out), .torque_off_active(torque_off_active),
		.torque_off_indicator(torque_off_indicator), .decel_request(decel_request),
		.drive_enabled(drive_enabled), .test_pulse(test_pulse),
		.self_test_fault(self_test_fault));
	function automatic int exp_enable(input int pins, input int sel);
		return (sel != 0) && ((pins & sel) == sel);
	endfunction
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic check_all(input int en, input int dec, input int fault);
		int off;
		off = !(chan_a && chan_b) || fault;
		check(pwm_out, (!off && en) ? pwm_request : 0, "pwm");
		check(torque_off_active, off, "torque off");
		check(drive_enabled, en && !off, "enabled");
		check(decel_request, dec, "decel");
		check(torque_off_indicator, (ind_assign && off) ? ind_high : !ind_high, "ind");
	endtask
	task automatic wait_pulse(input logic level);
		int n;
		n = 0;
		while (test_pulse !== level && n < 400) begin
			@(negedge clk);
			n++;
		end
		check(test_pulse, level, "pulse wait");
	endtask
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Ceiling well above the sum of all waits
	always @(posedge clk) begin
		cycles++;
		if (cycles >= 20000) begin
			miscompares++;
			print_verdict();
		end
	end
	initial begin
		settle(3);
		rst = 1'b0;
		settle(2);
		check_all(0, 0, 0);
		stop_request = 1'b0;
		pwm_request = 6'($random(seed));
		settle(6);
		check_all(1, 0, 0);
		wait_pulse(1'b1);
		for (k = 0; test_pulse === 1'b1 && k < 20; k++) @(negedge clk);
		check(k, 4, "pulse len");
		for (int i = 0; i < 12; i++) begin
			enable_select = (i == 0) ? 4'h1 : 4'($random(seed));
			other_inputs = 4'($random(seed));
			pwm_request = 6'($random(seed));
			settle(4);
			check_all(exp_enable(drive_input_pins, enable_select), 0, 0);
		end
		enable_select = 4'h1;
		for (int i = 0; i < 4; i++) begin
			{ind_assign, ind_high} = 2'(i);
			settle(4);
			open_wire_a = 1'b1;
			@(negedge clk);
			check(pwm_out, 0, "gate open");
			check(drive_enabled, 1, "core state");
			settle(4);
			check_all(1, 0, 0);
			open_wire_a = 1'b0;
			settle(6);
			check_all(1, 0, 0);
		end
		decel_on_disable = 1'b1;
		stop_request = 1'b1;
		settle(5);
		check_all(1, 1, 0);
		settle(30);
		check(pwm_out, 0, "stop gate");
		settle(4);
		check_all(0, 0, 0);
		stop_request = 1'b0;
		settle(6);
		stop_request = 1'b1;
		settle(5);
		decel_done = 1'b1;
		@(negedge clk);
		decel_done = 1'b0;
		settle(2);
		check_all(0, 0, 0);
		decel_on_disable = 1'b0;
		stop_request = 1'b0;
		resp_ok = 1'b0;
		settle(6);
		wait_pulse(1'b1);
		wait_pulse(1'b0);
		settle(4);
		check_all(1, 0, 1);
		check(self_test_fault, 1, "fault");
		resp_ok = 1'b1;
		wait_pulse(1'b1);
		wait_pulse(1'b0);
		settle(8);
		check(self_test_fault, 0, "fault clear");
		check_all(1, 0, 0);
		print_verdict();
	end
endmodule
